// [core/tfd_pkg.sv]
// Shared constants and carrier types for the terminal function decoder
package tfd_pkg;
	localparam int NUM_DI = 10;
	localparam int FIFTH_DI_IDX = 4;
	localparam int SEL_W = 6;
	localparam int FT_W = 10;
	localparam int FREQ_W = 16;
	// Function codes handled here
	localparam logic [5:0] FN_TORQUE_INHIBIT = 6'h1D;
	localparam logic [5:0] FN_PULSE_IN = 6'h1E;
	localparam logic [5:0] FN_DC_NOW = 6'h20;
	localparam logic [5:0] FN_EXT_FAULT_NC = 6'h21;
	localparam logic [5:0] FN_FREQ_LOCK = 6'h22;
	localparam logic [5:0] FN_PID_REVERSE = 6'h23;
	localparam logic [5:0] FN_EXT_STOP_ONE = 6'h24;
	localparam logic [5:0] FN_SRC_SWITCH_TWO = 6'h25;
	localparam logic [5:0] FN_INT_PAUSE = 6'h26;
	localparam logic [5:0] FN_MAIN_PRESET = 6'h27;
	localparam logic [5:0] FN_AUX_PRESET = 6'h28;
	localparam logic [5:0] FN_PID_SET = 6'h2B;
	localparam logic [5:0] FN_USER_FAULT_ONE = 6'h2C;
	localparam logic [5:0] FN_USER_FAULT_TWO = 6'h2D;
	localparam logic [5:0] FN_MODE_SWITCH = 6'h2E;
	localparam logic [5:0] FN_EMERG_STOP = 6'h2F;
	localparam logic [5:0] FN_EXT_STOP_TWO = 6'h30;
	localparam logic [5:0] FN_DECEL_DC = 6'h31;
	localparam logic [5:0] FN_RUN_TIME_CLR = 6'h32;
	localparam logic [5:0] FN_WIRE_SWITCH = 6'h33;
	// Command sources
	localparam logic [1:0] SRC_PANEL = 2'h0;
	localparam logic [1:0] SRC_TERMINAL = 2'h1;
	localparam logic [1:0] SRC_COMM = 2'h2;
	// Terminal command modes and deceleration time selection
	localparam logic [1:0] TMODE_TWO_LINE_ONE = 2'h0;
	localparam logic [1:0] TMODE_THREE_LINE_ONE = 2'h2;
	localparam logic [1:0] DECEL_TIME_FOUR = 2'h3;
	// Filter timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam logic [9:0] FILTER_MAX_MS = 10'h3E8;
	localparam logic [9:0] FILTER_DEFAULT_MS = 10'h00A;
	// Edge-event slots
	localparam int EV_DC_NOW = 0;
	localparam int EV_EXT_FAULT = 1;
	localparam int EV_USER_ONE = 2;
	localparam int EV_USER_TWO = 3;
	localparam int EV_DECEL_DC = 4;
	localparam int EV_RUN_CLR = 5;
	localparam int NUM_EV = 6;

	typedef logic [SEL_W-1:0] tfd_sel_t;

	typedef struct packed {
		logic [FT_W-1:0] input_filter_time;
		logic [1:0] terminal_command_mode;
		logic [1:0] cmd_source_setting;
		logic control_mode_setting;
		logic pid_direction_setting;
		logic pid_set_select_source;
		logic running_time_enable_a;
		logic running_time_enable_b;
		logic [1:0] user_fault_action_setting;
	} tfd_cfg_s;

	typedef struct packed {
		logic torque_mode;
		logic pulse_mode;
		logic dc_brake_now;
		logic external_fault_code;
		logic fault_stop;
		logic freq_lock;
		logic pid_reverse;
		logic panel_stop;
		logic [1:0] cmd_source;
		logic pid_integral_hold;
		logic main_preset_sel;
		logic aux_preset_sel;
		logic pid_set_two;
		logic user_fault_one_code;
		logic user_fault_two_code;
		logic fault_action_req;
		logic [1:0] fault_action;
		logic emergency_stop;
		logic current_limit_hold;
		logic decel_stop;
		logic [1:0] decel_time_sel;
		logic decel_dc_brake;
		logic run_time_clear;
		logic [1:0] terminal_mode;
	} tfd_cmd_s;

	localparam tfd_cmd_s CMD_RST = '0;
endpackage : tfd_pkg

// [core/tfd_decoder.sv]
// Digital input filter and terminal function decoder
`timescale 1ns/1ps

// Contract
// - Torque inhibit forces speed control mode
// - Pulse input honoured only on fifth input
// - Immediate DC brake enters braking at once
// - External fault input raises code and stops
// - Frequency lock ignores frequency change requests
// - PID reverse inverts configured PID direction
// - First external stop acts in panel mode
// - Source switch two: terminal to communication
// - Integral pause freezes only integral action
// - Substitution replaces source with preset frequency
// - User faults raise codes and action
// - Mode switchover inverts configured control mode
// - Emergency stop fastest at current limit
// - Second external stop decelerates with time four
// - Decelerating DC brake then braking state
// - Running time clear gated by enables
// - Two-line one switches to three-line one
// - Each input filtered up to one second
module tfd_decoder #(
	parameter int CYC_PER_MS = tfd_pkg::CYC_PER_MS
) (
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic ce,
	// Terminals and their function selections
	input wire logic [tfd_pkg::NUM_DI-1:0] di_raw,
	input wire tfd_pkg::tfd_sel_t [tfd_pkg::NUM_DI-1:0] di_func_sel,
	// Configuration
	input wire tfd_pkg::tfd_cfg_s cfg,
	// Frequency sources
	input wire logic [tfd_pkg::FREQ_W-1:0] main_freq_in,
	input wire logic [tfd_pkg::FREQ_W-1:0] aux_freq_in,
	input wire logic [tfd_pkg::FREQ_W-1:0] preset_frequency_value,
	// Decoded commands
	output tfd_pkg::tfd_cmd_s cmd,
	output logic [tfd_pkg::FREQ_W-1:0] main_freq_out,
	output logic [tfd_pkg::FREQ_W-1:0] aux_freq_out,
	output logic pulse_level
);

	// True when any input with this code is at its filtered active level
	function automatic logic fn_act(input tfd_pkg::tfd_sel_t [tfd_pkg::NUM_DI-1:0] sel,
			input logic [tfd_pkg::NUM_DI-1:0] lv, input logic [5:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < tfd_pkg::NUM_DI; i++) begin
			r = r | (lv[i] & (sel[i] == code));
		end
		return r;
	endfunction : fn_act

	// Filter time clamped to the one second ceiling
	function automatic logic [tfd_pkg::FT_W-1:0] fn_clamp(input logic [tfd_pkg::FT_W-1:0] t);
		return (t > tfd_pkg::FILTER_MAX_MS) ? tfd_pkg::FILTER_MAX_MS : t;
	endfunction : fn_clamp

	// Input filter state
	logic [31:0] pre_q;
	logic [31:0] pre_d;
	logic ms_tick;
	logic [tfd_pkg::NUM_DI-1:0] filt_q;
	logic [tfd_pkg::NUM_DI-1:0] filt_d;
	logic [tfd_pkg::NUM_DI-1:0][tfd_pkg::FT_W-1:0] cnt_q;
	logic [tfd_pkg::NUM_DI-1:0][tfd_pkg::FT_W-1:0] cnt_d;
	logic [tfd_pkg::FT_W-1:0] ftime;

	// Millisecond ticks are free running, so a change may settle up to one tick early
	always_comb begin
		ms_tick = (pre_q == 32'(CYC_PER_MS - 1));
		pre_d = ms_tick ? 32'h0 : pre_q + 32'h1;
		ftime = fn_clamp(cfg.input_filter_time);
		filt_d = filt_q;
		cnt_d = cnt_q;
		for (int i = 0; i < tfd_pkg::NUM_DI; i++) begin
			if (di_raw[i] == filt_q[i]) begin
				cnt_d[i] = '0;
			end else if (ftime == '0) begin
				filt_d[i] = di_raw[i];
			end else if (ms_tick) begin
				if (cnt_q[i] + 10'h001 >= ftime) begin
					filt_d[i] = di_raw[i];
					cnt_d[i] = '0;
				end else begin
					cnt_d[i] = cnt_q[i] + 10'h001;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pre_q <= 32'h0;
			filt_q <= '0;
			cnt_q <= '0;
		end else if (ce) begin
			pre_q <= pre_d;
			filt_q <= filt_d;
			cnt_q <= cnt_d;
		end
	end

	// Function activity from filtered levels; pulse mode from the fifth input's selection alone
	logic a_tinh, a_dc, a_xf, a_lock, a_prev, a_stop1, a_src2, a_ipause;
	logic a_mpre, a_apre, a_pset, a_uf1, a_uf2, a_msw, a_estop, a_stop2;
	logic a_ddc, a_rclr, a_wire, a_pulse;
	logic [tfd_pkg::NUM_EV-1:0] ev_lv;

	// Reserved codes have no decode term and so drive nothing
	always_comb begin
		a_tinh = fn_act(di_func_sel, filt_q, tfd_pkg::FN_TORQUE_INHIBIT);
		a_dc = fn_act(di_func_sel, filt_q, tfd_pkg::FN_DC_NOW);
		a_xf = fn_act(di_func_sel, filt_q, tfd_pkg::FN_EXT_FAULT_NC);
		a_lock = fn_act(di_func_sel, filt_q, tfd_pkg::FN_FREQ_LOCK);
		a_prev = fn_act(di_func_sel, filt_q, tfd_pkg::FN_PID_REVERSE);
		a_stop1 = fn_act(di_func_sel, filt_q, tfd_pkg::FN_EXT_STOP_ONE);
		a_src2 = fn_act(di_func_sel, filt_q, tfd_pkg::FN_SRC_SWITCH_TWO);
		a_ipause = fn_act(di_func_sel, filt_q, tfd_pkg::FN_INT_PAUSE);
		a_mpre = fn_act(di_func_sel, filt_q, tfd_pkg::FN_MAIN_PRESET);
		a_apre = fn_act(di_func_sel, filt_q, tfd_pkg::FN_AUX_PRESET);
		a_pset = fn_act(di_func_sel, filt_q, tfd_pkg::FN_PID_SET);
		a_uf1 = fn_act(di_func_sel, filt_q, tfd_pkg::FN_USER_FAULT_ONE);
		a_uf2 = fn_act(di_func_sel, filt_q, tfd_pkg::FN_USER_FAULT_TWO);
		a_msw = fn_act(di_func_sel, filt_q, tfd_pkg::FN_MODE_SWITCH);
		a_estop = fn_act(di_func_sel, filt_q, tfd_pkg::FN_EMERG_STOP);
		a_stop2 = fn_act(di_func_sel, filt_q, tfd_pkg::FN_EXT_STOP_TWO);
		a_ddc = fn_act(di_func_sel, filt_q, tfd_pkg::FN_DECEL_DC);
		a_rclr = fn_act(di_func_sel, filt_q, tfd_pkg::FN_RUN_TIME_CLR);
		a_wire = fn_act(di_func_sel, filt_q, tfd_pkg::FN_WIRE_SWITCH);
		// Pulse function on any other input is ignored
		a_pulse = (di_func_sel[tfd_pkg::FIFTH_DI_IDX] == tfd_pkg::FN_PULSE_IN);
		ev_lv = '0;
		ev_lv[tfd_pkg::EV_DC_NOW] = a_dc;
		ev_lv[tfd_pkg::EV_EXT_FAULT] = a_xf;
		ev_lv[tfd_pkg::EV_USER_ONE] = a_uf1;
		ev_lv[tfd_pkg::EV_USER_TWO] = a_uf2;
		ev_lv[tfd_pkg::EV_DECEL_DC] = a_ddc;
		ev_lv[tfd_pkg::EV_RUN_CLR] = a_rclr;
	end

	// Command outputs
	tfd_pkg::tfd_cmd_s cmd_q;
	tfd_pkg::tfd_cmd_s cmd_d;
	logic [tfd_pkg::NUM_EV-1:0] ev_q;
	logic [tfd_pkg::NUM_EV-1:0] ev_rise;
	logic [tfd_pkg::FREQ_W-1:0] mf_q, mf_d, af_q, af_d;
	logic pl_q, pl_d;

	always_comb begin
		ev_rise = ev_lv & ~ev_q;
		cmd_d = tfd_pkg::CMD_RST;
		// Inhibit overrides the switchover terminal
		cmd_d.torque_mode = a_tinh ? 1'b0 : (cfg.control_mode_setting ^ a_msw);
		cmd_d.pulse_mode = a_pulse;
		cmd_d.dc_brake_now = ev_rise[tfd_pkg::EV_DC_NOW];
		cmd_d.external_fault_code = ev_rise[tfd_pkg::EV_EXT_FAULT];
		cmd_d.fault_stop = a_xf;
		cmd_d.freq_lock = a_lock;
		cmd_d.pid_reverse = cfg.pid_direction_setting ^ a_prev;
		cmd_d.panel_stop = a_stop1 & (cfg.cmd_source_setting == tfd_pkg::SRC_PANEL);
		cmd_d.cmd_source = (a_src2 && cfg.cmd_source_setting == tfd_pkg::SRC_TERMINAL) ?
			tfd_pkg::SRC_COMM : cfg.cmd_source_setting;
		cmd_d.pid_integral_hold = a_ipause;
		cmd_d.main_preset_sel = a_mpre;
		cmd_d.aux_preset_sel = a_apre;
		cmd_d.pid_set_two = cfg.pid_set_select_source & a_pset;
		cmd_d.user_fault_one_code = ev_rise[tfd_pkg::EV_USER_ONE];
		cmd_d.user_fault_two_code = ev_rise[tfd_pkg::EV_USER_TWO];
		cmd_d.fault_action_req = ev_rise[tfd_pkg::EV_USER_ONE] | ev_rise[tfd_pkg::EV_USER_TWO];
		cmd_d.fault_action = cfg.user_fault_action_setting;
		cmd_d.emergency_stop = a_estop;
		cmd_d.current_limit_hold = a_estop;
		// Second stop works from any command source
		cmd_d.decel_stop = a_stop2;
		cmd_d.decel_time_sel = a_stop2 ? tfd_pkg::DECEL_TIME_FOUR : 2'h0;
		cmd_d.decel_dc_brake = ev_rise[tfd_pkg::EV_DECEL_DC];
		cmd_d.run_time_clear = ev_rise[tfd_pkg::EV_RUN_CLR] & cfg.running_time_enable_a
			& cfg.running_time_enable_b;
		cmd_d.terminal_mode = (a_wire && cfg.terminal_command_mode == tfd_pkg::TMODE_TWO_LINE_ONE) ?
			tfd_pkg::TMODE_THREE_LINE_ONE : cfg.terminal_command_mode;
		mf_d = a_mpre ? preset_frequency_value : main_freq_in;
		af_d = a_apre ? preset_frequency_value : aux_freq_in;
		// Pulses bypass the filter, which would swallow them
		pl_d = a_pulse & di_raw[tfd_pkg::FIFTH_DI_IDX];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cmd_q <= tfd_pkg::CMD_RST;
			ev_q <= '0;
			mf_q <= '0;
			af_q <= '0;
			pl_q <= 1'b0;
		end else if (ce) begin
			cmd_q <= cmd_d;
			ev_q <= ev_lv;
			mf_q <= mf_d;
			af_q <= af_d;
			pl_q <= pl_d;
		end
	end

	assign cmd = cmd_q;
	assign main_freq_out = mf_q;
	assign aux_freq_out = af_q;
	assign pulse_level = pl_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_dc_rise;
		ce && a_dc && !ev_q[tfd_pkg::EV_DC_NOW];
	endsequence

	sequence s_one_pulse_dc;
		cmd.dc_brake_now ##1 (ce ? !cmd.dc_brake_now : 1'b1);
	endsequence

	sequence s_clr_rise;
		ce && a_rclr && !ev_q[tfd_pkg::EV_RUN_CLR];
	endsequence

	AST_TORQUE_INHIBIT: assert property (ce && a_tinh |=> !cmd.torque_mode)
		else $error("torque mode while inhibited");
	AST_PULSE_FIFTH_ONLY: assert property (ce && di_func_sel[tfd_pkg::FIFTH_DI_IDX] != tfd_pkg::FN_PULSE_IN
		|=> !cmd.pulse_mode && !pulse_level)
		else $error("pulse mode without fifth input selection");
	AST_DC_NOW_PULSE: assert property (s_dc_rise ##0 ce[*1] |=> s_one_pulse_dc)
		else $error("immediate brake pulse wrong");
	AST_EXT_FAULT: assert property (ce && a_xf |=> cmd.fault_stop ##0 (cmd.external_fault_code
		== $past(!ev_q[tfd_pkg::EV_EXT_FAULT])))
		else $error("external fault not reported");
	AST_FREQ_LOCK: assert property (ce |=> cmd.freq_lock == $past(a_lock))
		else $error("frequency lock mismatch");
	AST_PID_REVERSE: assert property (ce && a_prev |=> cmd.pid_reverse != $past(cfg.pid_direction_setting))
		else $error("pid direction not inverted");
	AST_PANEL_STOP: assert property (ce && cfg.cmd_source_setting != tfd_pkg::SRC_PANEL |=> !cmd.panel_stop)
		else $error("panel stop outside panel mode");
	AST_SRC_SWITCH: assert property (ce && a_src2 && cfg.cmd_source_setting == tfd_pkg::SRC_TERMINAL
		|=> cmd.cmd_source == tfd_pkg::SRC_COMM)
		else $error("source not switched to communication");
	AST_PRESET_MAIN: assert property (ce && a_mpre |=> main_freq_out == $past(preset_frequency_value))
		else $error("main source not replaced by preset");
	AST_MODE_SWITCH: assert property (ce && !a_tinh |=> cmd.torque_mode
		== ($past(cfg.control_mode_setting) ^ $past(a_msw)))
		else $error("control mode switchover wrong");
	AST_DECEL_FOUR: assert property (ce && a_stop2 |=> cmd.decel_stop
		&& cmd.decel_time_sel == tfd_pkg::DECEL_TIME_FOUR)
		else $error("second stop without time four");
	AST_RUN_CLEAR: assert property (s_clr_rise |=> cmd.run_time_clear == $past(cfg.running_time_enable_a
		&& cfg.running_time_enable_b))
		else $error("running time clear gating wrong");
	AST_WIRE_SWITCH: assert property (ce && a_wire && cfg.terminal_command_mode == tfd_pkg::TMODE_TWO_LINE_ONE
		|=> cmd.terminal_mode == tfd_pkg::TMODE_THREE_LINE_ONE)
		else $error("wiring mode not switched");
	AST_FILTER_ZERO: assert property (ce && cfg.input_filter_time == '0 && di_raw[0] != filt_q[0]
		|=> filt_q[0] == $past(di_raw[0]))
		else $error("zero filter did not pass input");
	AST_FILTER_HOLD: assert property (ce && ms_tick == 1'b0 && cfg.input_filter_time != '0
		|=> $stable(filt_q))
		else $error("filtered level moved between ticks");

endmodule : tfd_decoder

// [verif/tfd_switch_bank.sv]
// Switch bank model driving the digital input terminals
`timescale 1ns/1ps
module tfd_switch_bank (
	// Clock
	input wire logic ref_clk,
	// Commanded contact states and terminal levels
	input wire logic [tfd_pkg::NUM_DI-1:0] sw_level,
	output logic [tfd_pkg::NUM_DI-1:0] di_raw
);
	// Contacts move just after an edge, like a real relay output
	always_ff @(posedge ref_clk) begin
		di_raw <= sw_level;
	end
endmodule : tfd_switch_bank

// [verif/terminal_function_decoder_tb.sv]
// Self-checking bench for the terminal function decoder
`timescale 1ns/1ps
module terminal_function_decoder_tb;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic [9:0] sw = '0;
	logic [9:0] di_raw;
	tfd_pkg::tfd_sel_t [9:0] sel = '0;
	tfd_pkg::tfd_cfg_s cfg = '0;
	tfd_pkg::tfd_cmd_s cmd;
	logic [15:0] main_out;
	logic [15:0] aux_out;
	logic pulse_level;
	int err_total = 0;
	int samples_checked = 0;
	localparam logic [15:0] MAIN_IN = 16'h1234;
	localparam logic [15:0] AUX_IN = 16'h5678;
	localparam logic [15:0] PRESET = 16'h0ABC;

	tfd_switch_bank sw_bank (.ref_clk(ref_clk), .sw_level(sw), .di_raw(di_raw));
	tfd_decoder #(.CYC_PER_MS(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .di_raw(di_raw),
		.di_func_sel(sel), .cfg(cfg), .main_freq_in(MAIN_IN), .aux_freq_in(AUX_IN),
		.preset_frequency_value(PRESET), .cmd(cmd), .main_freq_out(main_out), .aux_freq_out(aux_out),
		.pulse_level(pulse_level));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (e !== g) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	function automatic tfd_pkg::tfd_cmd_s exp_cmd(input logic [5:0] c, input logic act, input logic pul);
		tfd_pkg::tfd_cmd_s e;
		e = '0;
		e.torque_mode = cfg.control_mode_setting;
		e.cmd_source = cfg.cmd_source_setting;
		e.fault_action = cfg.user_fault_action_setting;
		e.terminal_mode = cfg.terminal_command_mode;
		e.pid_reverse = cfg.pid_direction_setting;
		if (act) begin
			case (c)
				tfd_pkg::FN_TORQUE_INHIBIT: e.torque_mode = 1'b0;
				tfd_pkg::FN_DC_NOW: e.dc_brake_now = pul;
				tfd_pkg::FN_EXT_FAULT_NC: begin
					e.external_fault_code = pul;
					e.fault_stop = 1'b1;
				end
				tfd_pkg::FN_FREQ_LOCK: e.freq_lock = 1'b1;
				tfd_pkg::FN_PID_REVERSE: e.pid_reverse = ~cfg.pid_direction_setting;
				tfd_pkg::FN_EXT_STOP_ONE: e.panel_stop = (cfg.cmd_source_setting == tfd_pkg::SRC_PANEL);
				tfd_pkg::FN_SRC_SWITCH_TWO: begin
					if (cfg.cmd_source_setting == tfd_pkg::SRC_TERMINAL) begin
						e.cmd_source = tfd_pkg::SRC_COMM;
					end
				end
				tfd_pkg::FN_INT_PAUSE: e.pid_integral_hold = 1'b1;
				tfd_pkg::FN_MAIN_PRESET: e.main_preset_sel = 1'b1;
				tfd_pkg::FN_AUX_PRESET: e.aux_preset_sel = 1'b1;
				tfd_pkg::FN_PID_SET: e.pid_set_two = cfg.pid_set_select_source;
				tfd_pkg::FN_USER_FAULT_ONE: begin
					e.user_fault_one_code = pul;
					e.fault_action_req = pul;
				end
				tfd_pkg::FN_USER_FAULT_TWO: begin
					e.user_fault_two_code = pul;
					e.fault_action_req = pul;
				end
				tfd_pkg::FN_MODE_SWITCH: e.torque_mode = ~cfg.control_mode_setting;
				tfd_pkg::FN_EMERG_STOP: begin
					e.emergency_stop = 1'b1;
					e.current_limit_hold = 1'b1;
				end
				tfd_pkg::FN_EXT_STOP_TWO: begin
					e.decel_stop = 1'b1;
					e.decel_time_sel = tfd_pkg::DECEL_TIME_FOUR;
				end
				tfd_pkg::FN_DECEL_DC: e.decel_dc_brake = pul;
				tfd_pkg::FN_RUN_TIME_CLR: e.run_time_clear = pul & cfg.running_time_enable_a & cfg.running_time_enable_b;
				tfd_pkg::FN_WIRE_SWITCH: begin
					if (cfg.terminal_command_mode == tfd_pkg::TMODE_TWO_LINE_ONE) begin
						e.terminal_mode = tfd_pkg::TMODE_THREE_LINE_ONE;
					end
				end
				default: e = e;
			endcase
		end
		return e;
	endfunction : exp_cmd

	// Press one terminal with one code, check the edge event, the level, and the return to idle
	task automatic hit(input int i, input logic [5:0] c);
		tfd_pkg::tfd_sel_t [9:0] s;
		s = '0;
		s[i] = c;
		@(posedge ref_clk);
		sel <= s;
		sw[i] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("cmd_event", 32'(exp_cmd(c, 1'b1, 1'b1)), 32'(cmd));
		chk("main_out", 32'((c == tfd_pkg::FN_MAIN_PRESET) ? PRESET : MAIN_IN), 32'(main_out));
		chk("aux_out", 32'((c == tfd_pkg::FN_AUX_PRESET) ? PRESET : AUX_IN), 32'(aux_out));
		@(posedge ref_clk);
		#1;
		chk("cmd_hold", 32'(exp_cmd(c, 1'b1, 1'b0)), 32'(cmd));
		@(posedge ref_clk);
		sw[i] <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("cmd_idle", 32'(exp_cmd(c, 1'b0, 1'b0)), 32'(cmd));
	endtask : hit

	initial begin
		#50000;
		err_total++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge ref_clk);
		rst_b <= 1'b1;
		// Two passes so every config-dependent branch but the PID set selection, the first running time enable and the filter time is taken both ways
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			cfg <= '{input_filter_time: 10'h000, terminal_command_mode: p ? 2'h1 : tfd_pkg::TMODE_TWO_LINE_ONE,
				cmd_source_setting: p ? tfd_pkg::SRC_PANEL : tfd_pkg::SRC_TERMINAL, control_mode_setting: ~p[0],
				pid_direction_setting: p[0], pid_set_select_source: 1'b1, running_time_enable_a: 1'b1,
				running_time_enable_b: ~p[0], user_fault_action_setting: 2'h2};
			for (int c = 29; c <= 51; c++) begin
				hit(0, 6'(c));
			end
		end
		// Independent inputs: pulse on fifth input, main substituted, aux left alone
		@(posedge ref_clk);
		sel <= {6'h00, 6'h00, 6'h00, 6'h00, 6'h00, tfd_pkg::FN_PULSE_IN, tfd_pkg::FN_AUX_PRESET, 6'h00,
			tfd_pkg::FN_MAIN_PRESET, 6'h00};
		sw <= 10'h012;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("pulse_mode", 32'h1, 32'(cmd.pulse_mode));
		chk("pulse_level", 32'h1, 32'(pulse_level));
		chk("main_out", 32'(PRESET), 32'(main_out));
		chk("aux_out", 32'(AUX_IN), 32'(aux_out));
		// Filter of 2 ms: a short blip is swallowed, a held level gets through in time
		@(posedge ref_clk);
		sw <= '0;
		sel <= {{8{tfd_pkg::FN_EMERG_STOP}}, 6'h00, 6'h00};
		cfg.input_filter_time <= 10'h002;
		repeat (12) @(posedge ref_clk);
		sw[3] <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sw[3] <= 1'b0;
		repeat (12) @(posedge ref_clk);
		#1;
		chk("blip", 32'h0, 32'(cmd.emergency_stop));
		@(posedge ref_clk);
		sw[3] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("early", 32'h0, 32'(cmd.emergency_stop));
		repeat (8) @(posedge ref_clk);
		#1;
		chk("held", 32'h1, 32'(cmd.emergency_stop));
		// Enable low freezes filter and outputs, release lets the drop through
		@(posedge ref_clk);
		ce <= 1'b0;
		sw[3] <= 1'b0;
		repeat (12) @(posedge ref_clk);
		#1;
		chk("frozen", 32'h1, 32'(cmd.emergency_stop));
		@(posedge ref_clk);
		ce <= 1'b1;
		repeat (12) @(posedge ref_clk);
		#1;
		chk("released", 32'h0, 32'(cmd.emergency_stop));
		tally_and_finish();
	end
endmodule : terminal_function_decoder_tb
